// [osc_pkg.sv]
package osc_pkg;
	// Register byte addresses
	localparam logic [31:0] USB_PLL_LOCK_STATUS_ADDR         = 32'h4004_8014;
	localparam logic [31:0] SYSTEM_OSCILLATOR_CONTROL_ADDR   = 32'h4004_8020;
	localparam logic [31:0] WATCHDOG_OSCILLATOR_CONTROL_ADDR = 32'h4004_8024;

	// Reset values
	localparam logic [31:0] USB_PLL_LOCK_STATUS_RST         = 32'h0000_0000;
	localparam logic [1:0]  SYSTEM_OSCILLATOR_CONTROL_RST   = 2'h0;
	localparam logic [8:0]  WATCHDOG_OSCILLATOR_CONTROL_RST = 9'h000;

	// Field layout
	localparam int LOCK_BIT     = 0;
	localparam int BYPASS_BIT   = 0;
	localparam int RANGE_BIT    = 1;
	localparam int SYSOSC_W     = 2;
	localparam int DIV_LSB      = 0;
	localparam int DIV_W        = 5;
	localparam int FREQ_LSB     = 5;
	localparam int FREQ_W       = 4;
	localparam int WDTOSC_W     = 9;
	localparam int BYTE_W       = 8;
	localparam int STRB_W       = 4;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : osc_pkg

// [slow_clk_div.sv]
`timescale 1ns/100ps
`default_nettype none
module slow_clk_div
	import osc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             tick_i,
	input  wire logic [DIV_W-1:0] div_i,
	output logic                  slow_clk_o
);
	logic [DIV_W-1:0] cnt_ff;
	logic             out_ff;
	logic             last_tick;

	assign slow_clk_o = out_ff;
	// A shrinking divider setting must not leave the count stranded above it
	assign last_tick  = (cnt_ff >= div_i);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= '0;
		end else if (tick_i) begin
			cnt_ff <= last_tick ? '0 : cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_ff <= 1'b0;
		end else if (tick_i && last_tick) begin
			out_ff <= ~out_ff;
		end
	end

	property p_toggle_on_wrap;
		@(posedge clk_i) disable iff (!rst_b_i)
		tick_i && last_tick |=> out_ff != $past(out_ff) && cnt_ff == '0;
	endproperty
	a_toggle_on_wrap: assert property (p_toggle_on_wrap) else $error("divider missed toggle");

	property p_toggle_only_on_tick;
		@(posedge clk_i) disable iff (!rst_b_i)
		$changed(out_ff) |-> $past(tick_i) && $past(last_tick);
	endproperty
	a_toggle_only_on_tick: assert property (p_toggle_only_on_tick) else $error("divider toggled early");

	c_full_ratio: cover property (@(posedge clk_i) disable iff (!rst_b_i) tick_i && div_i == 5'h1f && last_tick);
endmodule : slow_clk_div
`default_nettype wire

// [osc_config_and_pll_status.sv]
`timescale 1ns/100ps
`default_nettype none
module osc_config_and_pll_status
	import osc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// AXI4-Lite slave
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [STRB_W-1:0] s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Analog side
	input  wire logic              usb_pll_locked_i,
	input  wire logic              crystal_in_pin_i,
	input  wire logic              osc_out_clk_i,
	input  wire logic              wdt_ana_clk_i,
	output logic                   pll_in_clk_o,
	output logic                   osc_bypass_o,
	output logic                   osc_range_select_o,
	output logic [FREQ_W-1:0]      slow_osc_freq_code_o,
	output logic                   slow_clk_o
);
	logic [31:0]         wr_addr_ff;
	logic [31:0]         wr_data_ff;
	logic [STRB_W-1:0]   wr_strb_ff;
	logic                aw_held_ff;
	logic                w_held_ff;
	logic                bvalid_ff;
	logic [1:0]          bresp_ff;
	logic                rvalid_ff;
	logic [1:0]          rresp_ff;
	logic [31:0]         rdata_ff;
	logic [SYSOSC_W-1:0] sysosc_ff;
	logic [WDTOSC_W-1:0] wdtosc_ff;
	logic                lock_s1_ff;
	logic                lock_ff;
	logic                ana_s1_ff;
	logic                ana_s2_ff;
	logic                ana_s3_ff;
	logic                ana_tick;
	logic                do_write;
	logic                wr_sysosc;
	logic                wr_wdtosc;
	logic [31:0]         nxt_rdata;
	logic [1:0]          nxt_rresp;

	// Address and data are taken independently, one write in flight
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready  = !w_held_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;

	assign do_write  = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_sysosc = do_write && wr_addr_ff == SYSTEM_OSCILLATOR_CONTROL_ADDR;
	assign wr_wdtosc = do_write && wr_addr_ff == WATCHDOG_OSCILLATOR_CONTROL_ADDR;

	// Write address capture
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_held_ff <= 1'b0;
			wr_addr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			wr_addr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
	end

	// Write data capture
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			w_held_ff  <= 1'b0;
			wr_data_ff <= '0;
			wr_strb_ff <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff  <= 1'b1;
			wr_data_ff <= s_axi_wdata;
			wr_strb_ff <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
	end

	// Write response; the read-only status word accepts and ignores writes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (wr_sysosc || wr_wdtosc || wr_addr_ff == USB_PLL_LOCK_STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sysosc_ff <= SYSTEM_OSCILLATOR_CONTROL_RST;
		end else if (wr_sysosc && wr_strb_ff[0]) begin
			sysosc_ff <= wr_data_ff[SYSOSC_W-1:0];
		end
	end

	// Watchdog control; the code straddles lanes 0 and 1
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wdtosc_ff <= WATCHDOG_OSCILLATOR_CONTROL_RST;
		end else if (wr_wdtosc) begin
			if (wr_strb_ff[0]) begin
				wdtosc_ff[BYTE_W-1:0] <= wr_data_ff[BYTE_W-1:0];
			end
			if (wr_strb_ff[1]) begin
				wdtosc_ff[WDTOSC_W-1:BYTE_W] <= wr_data_ff[WDTOSC_W-1:BYTE_W];
			end
		end
	end

	// Read mux; unused upper bits read zero
	always_comb begin
		nxt_rdata = '0;
		nxt_rresp = RESP_OKAY;
		unique case (s_axi_araddr)
			USB_PLL_LOCK_STATUS_ADDR: begin
				nxt_rdata = USB_PLL_LOCK_STATUS_RST;
				nxt_rdata[LOCK_BIT] = lock_ff;
			end
			SYSTEM_OSCILLATOR_CONTROL_ADDR: begin
				nxt_rdata[SYSOSC_W-1:0] = sysosc_ff;
			end
			WATCHDOG_OSCILLATOR_CONTROL_ADDR: begin
				nxt_rdata[WDTOSC_W-1:0] = wdtosc_ff;
			end
			default: begin
				nxt_rresp = RESP_SLVERR;
			end
		endcase
	end

	// Read response, one cycle after the address
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= RESP_OKAY;
			rdata_ff  <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= nxt_rresp;
			rdata_ff  <= nxt_rdata;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lock_s1_ff <= 1'b0;
			lock_ff    <= 1'b0;
		end else begin
			lock_s1_ff <= usb_pll_locked_i;
			lock_ff    <= lock_s1_ff;
		end
	end

	// Analog clock sampled into a tick; far below clk so no edge is lost
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ana_s1_ff <= 1'b0;
			ana_s2_ff <= 1'b0;
			ana_s3_ff <= 1'b0;
		end else begin
			ana_s1_ff <= wdt_ana_clk_i;
			ana_s2_ff <= ana_s1_ff;
			ana_s3_ff <= ana_s2_ff;
		end
	end
	assign ana_tick = ana_s2_ff && !ana_s3_ff;

	// Clock mux; a glitch on switch is the user's to avoid
	assign pll_in_clk_o         = sysosc_ff[BYPASS_BIT] ? crystal_in_pin_i : osc_out_clk_i;
	assign osc_bypass_o         = sysosc_ff[BYPASS_BIT];
	assign osc_range_select_o   = sysosc_ff[RANGE_BIT];
	assign slow_osc_freq_code_o = wdtosc_ff[FREQ_LSB +: FREQ_W];

	slow_clk_div u_div (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.tick_i     (ana_tick),
		.div_i      (wdtosc_ff[DIV_LSB +: DIV_W]),
		.slow_clk_o (slow_clk_o)
	);

	property p_lock_read;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == USB_PLL_LOCK_STATUS_ADDR
			|=> s_axi_rvalid && s_axi_rdata[LOCK_BIT] == $past(lock_ff) && s_axi_rdata[31:1] == '0;
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock bit misread");

	property p_bypass_mux;
		@(posedge clk_i) disable iff (!rst_b_i)
		pll_in_clk_o == (osc_bypass_o ? crystal_in_pin_i : osc_out_clk_i);
	endproperty
	a_bypass_mux: assert property (p_bypass_mux) else $error("wrong pll input source");

	property p_range_write;
		@(posedge clk_i) disable iff (!rst_b_i)
		$rose(s_axi_bvalid) && wr_addr_ff == SYSTEM_OSCILLATOR_CONTROL_ADDR && wr_strb_ff[0]
			|-> osc_range_select_o == wr_data_ff[RANGE_BIT] && osc_bypass_o == wr_data_ff[BYPASS_BIT];
	endproperty
	a_range_write: assert property (p_range_write) else $error("range not updated");

	property p_freq_write;
		@(posedge clk_i) disable iff (!rst_b_i)
		$rose(s_axi_bvalid) && wr_addr_ff == WATCHDOG_OSCILLATOR_CONTROL_ADDR && wr_strb_ff[1:0] == 2'h3
			|-> slow_osc_freq_code_o == wr_data_ff[FREQ_LSB +: FREQ_W];
	endproperty
	a_freq_write: assert property (p_freq_write) else $error("frequency code not updated");

	property p_write_resp;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write response dropped"); // Bus response hold

	c_bypass_on: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(osc_bypass_o));
	c_lock_read: cover property (@(posedge clk_i) disable iff (!rst_b_i) s_axi_rvalid && s_axi_rdata[LOCK_BIT]);
	c_unmapped:  cover property (@(posedge clk_i) disable iff (!rst_b_i) s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : osc_config_and_pll_status
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench
	import osc_pkg::*;
;
	logic              clk_i = 1'b0, rst_b_i = 1'b0;
	logic [31:0]       s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [STRB_W-1:0] s_axi_wstrb = 4'hf;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              usb_pll_locked_i = 1'b0, crystal_in_pin_i = 1'b1, osc_out_clk_i = 1'b0;
	logic              wdt_ana_clk_i = 1'b0, pll_in_clk_o, osc_bypass_o, osc_range_select_o, slow_clk_o;
	logic [FREQ_W-1:0] slow_osc_freq_code_o;
	logic [1:0]        ana_cnt = 2'h0;
	int                n_fail = 0, n_compared = 0;

	osc_config_and_pll_status u_osc_config_and_pll_status (
		.clk_i                (clk_i),
		.rst_b_i              (rst_b_i),
		.s_axi_awaddr         (s_axi_awaddr),
		.s_axi_awvalid        (s_axi_awvalid),
		.s_axi_awready        (s_axi_awready),
		.s_axi_wdata          (s_axi_wdata),
		.s_axi_wstrb          (s_axi_wstrb),
		.s_axi_wvalid         (s_axi_wvalid),
		.s_axi_wready         (s_axi_wready),
		.s_axi_bresp          (s_axi_bresp),
		.s_axi_bvalid         (s_axi_bvalid),
		.s_axi_bready         (s_axi_bready),
		.s_axi_araddr         (s_axi_araddr),
		.s_axi_arvalid        (s_axi_arvalid),
		.s_axi_arready        (s_axi_arready),
		.s_axi_rdata          (s_axi_rdata),
		.s_axi_rresp          (s_axi_rresp),
		.s_axi_rvalid         (s_axi_rvalid),
		.s_axi_rready         (s_axi_rready),
		.usb_pll_locked_i     (usb_pll_locked_i),
		.crystal_in_pin_i     (crystal_in_pin_i),
		.osc_out_clk_i        (osc_out_clk_i),
		.wdt_ana_clk_i        (wdt_ana_clk_i),
		.pll_in_clk_o         (pll_in_clk_o),
		.osc_bypass_o         (osc_bypass_o),
		.osc_range_select_o   (osc_range_select_o),
		.slow_osc_freq_code_o (slow_osc_freq_code_o),
		.slow_clk_o           (slow_clk_o)
	);

	always #5 clk_i = ~clk_i;

	// Analog clock at an eighth of the bus clock, well under the sampler limit
	always @(posedge clk_i) begin
		ana_cnt <= ana_cnt + 2'h1;
		if (ana_cnt == 2'h3) wdt_ana_clk_i <= ~wdt_ana_clk_i;
	end

	task automatic print_verdict();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic timeout();
		n_fail++;
		$display("[ERR] %0t handshake never came", $time);
		print_verdict();
	endtask : timeout

	// Both channels offered together, each dropped on its own acceptance
	task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
		int   i;
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50 && (aw || w); i++) begin
			@(posedge clk_i);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (aw || w) timeout();
		for (i = 0; i < 50 && !(i > 0 && s_axi_bvalid); i++) @(posedge clk_i);
		if (!s_axi_bvalid) timeout();
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
		// One edge between calls, so bready is never driven twice in one step
		@(posedge clk_i);
	endtask : wr

	task automatic rd(input logic [31:0] a, d, input logic [1:0] er);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50 && !(i > 0 && s_axi_arready); i++) @(posedge clk_i);
		if (!s_axi_arready) timeout();
		s_axi_arvalid <= 1'b0;
		for (i = 0; i < 50 && !s_axi_rvalid; i++) @(posedge clk_i);
		if (!s_axi_rvalid) timeout();
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, d);
		chk(32'(s_axi_rresp), 32'(er));
		// One edge between calls, so rready is never driven twice in one step
		@(posedge clk_i);
	endtask : rd

	// Cycles between two slow clock edges after it has settled on the divider
	task automatic period(input logic [4:0] dv);
		int i, n;
		logic s;
		wr(WATCHDOG_OSCILLATOR_CONTROL_ADDR, {23'h0, 4'h3, dv}, 4'hf, RESP_OKAY);
		for (n = 0; n < 3; n++) begin
			s = slow_clk_o;
			for (i = 0; i < 2000 && slow_clk_o === s; i++) @(posedge clk_i);
			if (i == 2000) timeout();
		end
		chk(32'(i), 32'((int'(dv) + 1) * 8));
	endtask : period

	initial begin
		int v;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		// Slow clock at its reset level before the first analog tick can reach it
		chk(32'(slow_clk_o), 32'h0);
		// Reset values of every word
		rd(USB_PLL_LOCK_STATUS_ADDR, 32'h0, RESP_OKAY);
		rd(SYSTEM_OSCILLATOR_CONTROL_ADDR, 32'h0, RESP_OKAY);
		rd(WATCHDOG_OSCILLATOR_CONTROL_ADDR, 32'h0, RESP_OKAY);
		// Lock follows the input; writes to it change nothing
		usb_pll_locked_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(USB_PLL_LOCK_STATUS_ADDR, 32'h1, RESP_OKAY);
		wr(USB_PLL_LOCK_STATUS_ADDR, 32'h0, 4'hf, RESP_OKAY);
		rd(USB_PLL_LOCK_STATUS_ADDR, 32'h1, RESP_OKAY);
		usb_pll_locked_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(USB_PLL_LOCK_STATUS_ADDR, 32'h0, RESP_OKAY);
		// Every bypass and range setting, both clock sources swapped
		for (v = 0; v < 4; v++) begin
			wr(SYSTEM_OSCILLATOR_CONTROL_ADDR, 32'(v), 4'hf, RESP_OKAY);
			chk(32'(osc_bypass_o), 32'(v % 2));
			chk(32'(osc_range_select_o), 32'(v / 2));
			crystal_in_pin_i <= 1'b0;
			osc_out_clk_i <= 1'b1;
			@(posedge clk_i);
			chk(32'(pll_in_clk_o), 32'(v % 2 == 0));
			crystal_in_pin_i <= 1'b1;
			osc_out_clk_i <= 1'b0;
			@(posedge clk_i);
			chk(32'(pll_in_clk_o), 32'(v % 2));
			rd(SYSTEM_OSCILLATOR_CONTROL_ADDR, 32'(v), RESP_OKAY);
		end
		// Frequency codes 1 to 15
		for (v = 1; v < 16; v++) begin
			wr(WATCHDOG_OSCILLATOR_CONTROL_ADDR, 32'(v) << FREQ_LSB, 4'hf, RESP_OKAY);
			chk(32'(slow_osc_freq_code_o), 32'(v));
			rd(WATCHDOG_OSCILLATOR_CONTROL_ADDR, 32'(v) << FREQ_LSB, RESP_OKAY);
		end
		// Low lane only: top code bit keeps its old value
		wr(WATCHDOG_OSCILLATOR_CONTROL_ADDR, 32'h0000_001f, 4'h1, RESP_OKAY);
		rd(WATCHDOG_OSCILLATOR_CONTROL_ADDR, 32'h0000_011f, RESP_OKAY);
		// Divider at both ends and in between
		period(5'h00);
		period(5'h03);
		period(5'h1f);
		// Unmapped words refused, nothing disturbed
		wr(32'h4004_8018, 32'hffff_ffff, 4'hf, RESP_SLVERR);
		rd(32'h4004_8028, 32'h0, RESP_SLVERR);
		rd(SYSTEM_OSCILLATOR_CONTROL_ADDR, 32'h3, RESP_OKAY);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
